/* core/i2r_pkg.sv */
// constants, state types and reset values of the two-wire register read slave
// assumes the bus pins are sampled on CLK (125 MHz) and the register file answers in the strobe cycle
package i2r_pkg;
   localparam logic [2:0] I2R_OPC_READ = 3'h4;
   localparam int I2R_OPC_MSB = 2;
   localparam int I2R_PORT_HI_BIT = 0;
   localparam int I2R_PORT_LO_BIT = 7;
   localparam int I2R_BE_MSB = 5;
   localparam int I2R_BE_LSB = 2;
   localparam int I2R_ADDR_HI_MSB = 1;
   localparam int I2R_NUM_PORTS = 3;
   localparam logic [3:0] I2R_BITS_PER_BYTE = 4'h8;
   localparam logic [1:0] I2R_LAST_CMD = 2'h3;
   localparam logic [1:0] I2R_FIRST_TX = 2'h0;
   localparam logic I2R_PIN_IDLE = 1'h1;

   typedef enum logic [2:0] {I2R_IDLE, I2R_ADDR, I2R_ADDR_ACK, I2R_CMD, I2R_CMD_ACK,
      I2R_TX, I2R_TX_ACK} i2r_phase_t;

   typedef struct packed {
      i2r_phase_t state;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic rw;
      logic [2:0] cidx;
      logic [3:0][7:0] cmd;
      logic [31:0] buf_w;
      logic [1:0] tidx;
      logic [7:0] tx_sh;
      logic nack;
      logic oe;
      logic rd;
      logic [2:0] port_sel;
      logic [11:0] addr;
      logic [3:0] be;
   } i2r_state_t;

   localparam i2r_state_t I2R_RST = '{state: I2R_IDLE, default: '0};
endpackage

/* core/i2r_sync.sv */
// two-stage synchroniser with a third stage kept for edge detection
// assumes d comes from pins outside the CLK domain, idle high
`timescale 1ns/1ns
module i2r_sync #(
   parameter int W = 2
) (
   input wire logic clk, // sampling clock
   input wire logic rst, // synchronous, active high
   input wire logic [W-1:0] d, // asynchronous pins
   output logic [W-1:0] q, // synchronised level
   output logic [W-1:0] q_prev // level one cycle earlier
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] lvl;
      logic [W-1:0] prev;
   } i2r_sync_t;

   i2r_sync_t s_q, s_d;

   // only the second and third stages reach the outputs; the first is never decoded
   always_comb
   begin
      s_d.meta = d;
      s_d.lvl = s_q.meta;
      s_d.prev = s_q.lvl;
   end

   // idle-high reset keeps a false edge from following reset
   always_ff @(posedge clk)
   begin
      if (rst)
         s_q <= {3{{W{i2r_pkg::I2R_PIN_IDLE}}}};
      else
         s_q <= s_d;
   end

   assign q = s_q.lvl;
   assign q_prev = s_q.prev;
endmodule

/* core/i2r_slave.sv */
// two-wire slave serving register read commands from a 32-bit capture buffer
// assumes SCL/SDA pins are asynchronous; register fetch answers in the strobe cycle
`timescale 1ns/1ns
module i2r_slave (
   input wire logic CLK, // system clock, 125 MHz
   input wire logic SYS_RST, // synchronous reset, active high
   input wire logic SCL_I, // bus clock pin level
   input wire logic SDA_I, // bus data pin level
   output logic SDA_O, // data drive value, always low
   output logic SDA_OE, // high while pulling data low
   input wire logic [6:0] SLV_ADDR, // own 7-bit address, from CLK logic
   output logic REG_RD, // one-cycle register fetch strobe
   output logic [2:0] REG_PORT_SEL, // one-hot switch port select
   output logic [11:0] REG_ADDR, // dword-aligned register address
   output logic [3:0] REG_BE, // byte enables from the command
   input wire logic [31:0] REG_RDATA // fetched register value
);
   i2r_pkg::i2r_state_t r_q, r_d;
   logic [1:0] pin_q, pin_p;
   logic scl_rise, scl_fall, start_det, stop_det;

   i2r_sync #(.W(2)) u_sync (
      .clk(CLK),
      .rst(SYS_RST),
      .d({SCL_I, SDA_I}),
      .q(pin_q),
      .q_prev(pin_p)
   );

   function automatic logic [7:0] buf_byte(input logic [31:0] w, input logic [1:0] idx);
      buf_byte = w[31 - 8 * idx -: 8];
   endfunction

   assign scl_rise = pin_q[1] & ~pin_p[1];
   assign scl_fall = ~pin_q[1] & pin_p[1];
   assign start_det = pin_q[1] & pin_p[1] & ~pin_q[0] & pin_p[0];
   assign stop_det = pin_q[1] & pin_p[1] & pin_q[0] & ~pin_p[0];

   always_comb
   begin
      logic [1:0] pidx;
      pidx = '0;
      r_d = r_q;
      r_d.rd = 1'b0;
      if (r_q.rd)
         r_d.buf_w = REG_RDATA;
      if (start_det)
      begin
         // repeated start keeps the command and buffer
         r_d.state = i2r_pkg::I2R_ADDR;
         r_d.cnt = '0;
         r_d.oe = 1'b0;
      end
      else if (stop_det)
      begin
         r_d.state = i2r_pkg::I2R_IDLE;
         r_d.oe = 1'b0;
      end
      else
      begin
         unique case (r_q.state)
            i2r_pkg::I2R_IDLE: ;
            i2r_pkg::I2R_ADDR, i2r_pkg::I2R_CMD:
            begin
               if (scl_rise)
               begin
                  r_d.sh = {r_q.sh[6:0], pin_q[0]};
                  r_d.cnt = r_q.cnt + 4'h1;
               end
               else if (scl_fall && r_q.cnt == i2r_pkg::I2R_BITS_PER_BYTE)
               begin
                  r_d.oe = 1'b1;
                  if (r_q.state == i2r_pkg::I2R_ADDR)
                  begin
                     if (r_q.sh[7:1] == SLV_ADDR)
                     begin
                        r_d.state = i2r_pkg::I2R_ADDR_ACK;
                        r_d.rw = r_q.sh[0];
                     end
                     else
                     begin
                        r_d.state = i2r_pkg::I2R_IDLE;
                        r_d.oe = 1'b0;
                     end
                  end
                  else
                  begin
                     r_d.state = i2r_pkg::I2R_CMD_ACK;
                     if (r_q.cidx < 3'h4)
                     begin
                        r_d.cmd[r_q.cidx[1:0]] = r_q.sh;
                        r_d.cidx = r_q.cidx + 3'h1;
                     end
                     pidx = {r_d.cmd[1][i2r_pkg::I2R_PORT_HI_BIT],
                        r_d.cmd[2][i2r_pkg::I2R_PORT_LO_BIT]};
                     // port index 3 names no port, so no fetch and the buffer stays
                     if (r_q.cidx == {1'b0, i2r_pkg::I2R_LAST_CMD}
                        && r_d.cmd[0][i2r_pkg::I2R_OPC_MSB:0] == i2r_pkg::I2R_OPC_READ
                        && 32'(pidx) < i2r_pkg::I2R_NUM_PORTS)
                     begin
                        r_d.rd = 1'b1;
                        r_d.port_sel = 3'h1 << pidx;
                        r_d.be = r_d.cmd[2][i2r_pkg::I2R_BE_MSB:i2r_pkg::I2R_BE_LSB];
                        r_d.addr = {r_d.cmd[2][i2r_pkg::I2R_ADDR_HI_MSB:0],
                           r_d.cmd[3], 2'h0};
                     end
                  end
               end
            end
            i2r_pkg::I2R_ADDR_ACK:
            begin
               if (scl_fall)
               begin
                  r_d.cnt = '0;
                  if (r_q.rw)
                  begin
                     r_d.state = i2r_pkg::I2R_TX;
                     r_d.tidx = i2r_pkg::I2R_FIRST_TX;
                     r_d.tx_sh = buf_byte(r_q.buf_w, i2r_pkg::I2R_FIRST_TX);
                     r_d.oe = ~r_d.tx_sh[7];
                     r_d.cnt = 4'h1;
                  end
                  else
                  begin
                     r_d.state = i2r_pkg::I2R_CMD;
                     r_d.cidx = '0;
                     r_d.oe = 1'b0;
                  end
               end
            end
            i2r_pkg::I2R_CMD_ACK:
            begin
               if (scl_fall)
               begin
                  r_d.state = i2r_pkg::I2R_CMD;
                  r_d.cnt = '0;
                  r_d.oe = 1'b0;
               end
            end
            i2r_pkg::I2R_TX:
            begin
               if (scl_fall)
               begin
                  if (r_q.cnt == i2r_pkg::I2R_BITS_PER_BYTE)
                  begin
                     r_d.state = i2r_pkg::I2R_TX_ACK;
                     r_d.oe = 1'b0;
                  end
                  else
                  begin
                     r_d.oe = ~r_q.tx_sh[6];
                     r_d.tx_sh = {r_q.tx_sh[6:0], 1'b0};
                     r_d.cnt = r_q.cnt + 4'h1;
                  end
               end
            end
            i2r_pkg::I2R_TX_ACK:
            begin
               if (scl_rise)
                  r_d.nack = pin_q[0];
               else if (scl_fall)
               begin
                  if (r_q.nack)
                     r_d.state = i2r_pkg::I2R_IDLE;
                  else
                  begin
                     // 2-bit index rolls 3 -> 0, restarting at byte 3
                     r_d.tidx = r_q.tidx + 2'h1;
                     r_d.tx_sh = buf_byte(r_q.buf_w, r_d.tidx);
                     r_d.oe = ~r_d.tx_sh[7];
                     r_d.cnt = 4'h1;
                     r_d.state = i2r_pkg::I2R_TX;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
         r_q <= i2r_pkg::I2R_RST;
      else
         r_q <= r_d;
   end

   assign SDA_O = 1'b0;
   assign SDA_OE = r_q.oe;
   assign REG_RD = r_q.rd;
   assign REG_PORT_SEL = r_q.port_sel;
   assign REG_ADDR = r_q.addr;
   assign REG_BE = r_q.be;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   sequence nack_end_s;
      r_q.state == i2r_pkg::I2R_TX_ACK && scl_fall && r_q.nack;
   endsequence
   sequence wrap_s;
      r_q.state == i2r_pkg::I2R_TX_ACK && scl_fall && !r_q.nack && r_q.tidx == 2'h3;
   endsequence
   sequence fetch_s;
      r_q.rd ##1 1'b1;
   endsequence

   buffer_load_a: assert property (fetch_s |-> r_q.buf_w == $past(REG_RDATA))
      else $error("buffer did not take fetched value");
   buffer_hold_a: assert property (!r_q.rd |=> $stable(r_q.buf_w))
      else $error("buffer changed without a fetch");
   opcode_check_a: assert property (REG_RD |-> r_q.cmd[0][2:0] == 3'h4)
      else $error("fetch without read opcode");
   port_select_a: assert property (REG_RD |-> REG_PORT_SEL
      == 3'(3'h1 << {r_q.cmd[1][0], r_q.cmd[2][7]}) && REG_PORT_SEL != 3'h0)
      else $error("port select mismatch");
   reg_addr_a: assert property (REG_RD |-> REG_ADDR == {r_q.cmd[2][1:0], r_q.cmd[3], 2'h0}
      && REG_BE == r_q.cmd[2][5:2])
      else $error("address or enables mismatch");
   first_byte_a: assert property (r_q.state == i2r_pkg::I2R_ADDR_ACK && scl_fall && r_q.rw
      |=> r_q.tx_sh == r_q.buf_w[31:24] && SDA_OE == ~r_q.buf_w[31])
      else $error("read did not start with byte 3");
   wrap_around_a: assert property (wrap_s |=> r_q.tidx == 2'h0
      && r_q.tx_sh == r_q.buf_w[31:24])
      else $error("no wrap to byte 3");
   nack_release_a: assert property (nack_end_s |=> !SDA_OE
      && r_q.state == i2r_pkg::I2R_IDLE)
      else $error("data line held after nack");
   stop_release_a: assert property (stop_det && !start_det |=> !SDA_OE [*2])
      else $error("data line held after stop");
   restart_a: assert property (start_det |=> r_q.state == i2r_pkg::I2R_ADDR
      && $stable(r_q.cmd))
      else $error("repeated start not taken");
endmodule

/* test/i2r_bus_master.sv */
// two-wire bus master model: open-drain clock and data, 1 = released
// assumes the bench resolves the data line and feeds it back on sda_line
`timescale 1ns/1ns
module i2r_bus_master (
   input wire logic clk, // bench clock, levels change at its falling edge
   input wire logic sda_line, // resolved data line
   output logic scl, // bus clock, 64 ns period, stands high between frames
   output logic sda // data drive, 1 = released to pull-up
);
   initial
   begin
      scl = 1'b1;
      sda = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   // low phase is 5 cycles so a slave release lands before the rise
   task automatic start();
      tick(2);
      sda = 1'b1;
      tick(3);
      scl = 1'b1;
      tick(2);
      sda = 1'b0;
      tick(2);
      scl = 1'b0;
   endtask
   task automatic xfer(input logic b, output logic got);
      tick(2);
      sda = b;
      tick(3);
      scl = 1'b1;
      tick(2);
      got = sda_line;
      tick(1);
      scl = 1'b0;
   endtask
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic g;
      for (int i = 7; i >= 0; i--)
      begin
         xfer(b[i], g);
      end
      xfer(1'b1, ack);
   endtask
   // ack keeps the slave sending, nack on the last byte ends it
   task automatic rbyte(input logic last, output logic [7:0] b);
      logic g;
      for (int i = 7; i >= 0; i--)
      begin
         xfer(1'b1, g);
         b[i] = g;
      end
      xfer(last, g);
   endtask
   task automatic stop();
      tick(2);
      sda = 1'b0;
      tick(3);
      scl = 1'b1;
      tick(2);
      sda = 1'b1;
      tick(4);
   endtask
endmodule

/* test/tb_top.sv */
// bench for the register read slave: master model on the bus, register file stub
// assumes the stub answers combinationally while the fetch strobe is high
`timescale 1ns/1ns
module tb_top;
   localparam logic [6:0] own_addr = 7'h2b;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic m_scl, m_sda, sda_line, sda_o, sda_oe, reg_rd;
   logic [2:0] port_sel;
   logic [11:0] reg_addr;
   logic [3:0] reg_be;
   logic [31:0] reg_rdata, seen_fetch;
   logic [31:0] exp_buf = 32'h00000000;
   int bad_count = 0;
   int comparisons = 0;
   int fetches = 0;
   always #4 clk = ~clk;
   assign sda_line = sda_oe ? (sda_o & m_sda) : m_sda;
   // reg_be and port_sel land in bytes of their own, reg_addr in the low two bytes, so ordering slips show
   assign reg_rdata = {4'ha, reg_be, 5'h00, port_sel, 4'h0, reg_addr};
   i2r_bus_master m (.clk(clk), .sda_line(sda_line), .scl(m_scl), .sda(m_sda));
   i2r_slave uut (.CLK(clk), .SYS_RST(sys_rst), .SCL_I(m_scl), .SDA_I(sda_line),
      .SDA_O(sda_o), .SDA_OE(sda_oe), .SLV_ADDR(own_addr), .REG_RD(reg_rd),
      .REG_PORT_SEL(port_sel), .REG_ADDR(reg_addr), .REG_BE(reg_be), .REG_RDATA(reg_rdata));
   always @(posedge clk)
   begin
      if (reg_rd === 1'b1)
      begin
         fetches <= fetches + 1;
         seen_fetch <= reg_rdata;
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_ack(input string what, input logic exp, input logic got);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic run_read(input logic [2:0] opc, input logic [1:0] port, input logic [3:0] be,
      input logic [11:0] addr, input logic joined, input int nbytes);
      logic a;
      logic go;
      logic [7:0] b;
      logic [7:0] cmd [4];
      int f0;
      cmd[0] = {5'h00, opc};
      cmd[1] = {7'h00, port[1]};
      cmd[2] = {port[0], 1'b0, be, addr[11:10]};
      cmd[3] = addr[9:2];
      go = (opc === i2r_pkg::I2R_OPC_READ) && (port !== 2'h3);
      f0 = fetches;
      m.start();
      m.wbyte({own_addr, 1'b0}, a);
      chk_ack("write address ack", 1'b0, a);
      for (int i = 0; i < 4; i++)
      begin
         m.wbyte(cmd[i], a);
         chk_ack("command ack", 1'b0, a);
      end
      if (go)
      begin
         exp_buf = {4'ha, be, 5'h00, 3'h1 << port, 4'h0, addr[11:2], 2'h0};
      end
      chk("fetch count", f0 + int'(go), fetches);
      chk("fetch fields", exp_buf, seen_fetch);
      if (joined)
         m.start();
      else
      begin
         m.stop();
         m.start();
      end
      m.wbyte({own_addr, 1'b1}, a);
      chk_ack("read address ack", 1'b0, a);
      for (int i = 0; i < nbytes; i++)
      begin
         m.rbyte(i == nbytes - 1, b);
         chk("read byte", {24'h0, exp_buf[8 * (3 - i % 4) +: 8]}, {24'h0, b});
      end
      m.stop();
      chk_ack("data released", 1'b0, sda_oe);
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      #400000;
      bad_count++;
      summarize();
   end
   initial
   begin
      logic a;
      repeat (3) @(negedge clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge clk);
      run_read(3'h4, 2'h0, 4'hf, 12'h0b4, 1'b0, 6);
      run_read(3'h4, 2'h2, 4'h5, 12'hffc, 1'b1, 4);
      run_read(3'h4, 2'h1, 4'ha, 12'h400, 1'b0, 5);
      run_read(3'h3, 2'h0, 4'hf, 12'h010, 1'b1, 4);
      run_read(3'h4, 2'h3, 4'hf, 12'h020, 1'b0, 4);
      m.start();
      m.wbyte({own_addr ^ 7'h01, 1'b0}, a);
      chk_ack("foreign address ack", 1'b1, a);
      m.stop();
      summarize();
   end
endmodule
